/* hdl/sfcd_regs.vh */
// Overview of operation
// - Page program on 02 or 12, 133 MHz
// - Quad page program on 32, 38, 34
// - Block wipe on D8 or DC
// - Chip wipe on 60 or C7
// - Busy flag high during embedded operations
// - Separate program and erase fail flags
// - Busy stays high while fail latched
// - Only five commands accepted while failed
// - Clear status zeroes busy and fails
// - Write lock clears write latch flag
// - Hardware or software reset restores standby
// - Nonvolatile register bits rewritten as one
// - Opcode A3 reserved, no action
// - Status reads on 05 and 07
// - Clear error status on 30
// - Page program takes 1 to 512 bytes
`ifndef SFCD_REGS_VH
`define SFCD_REGS_VH
`define SFCD_PAGE_PROGRAM_CMD          8'h02
`define SFCD_PAGE_PROGRAM_4B_CMD       8'h12
`define SFCD_QUAD_PAGE_PROGRAM_CMD     8'h32
`define SFCD_QUAD_PAGE_PROGRAM_ALT_CMD 8'h38
`define SFCD_QUAD_PAGE_PROGRAM_4B_CMD  8'h34
`define SFCD_BLOCK_WIPE_512K_CMD       8'hD8
`define SFCD_BLOCK_WIPE_512K_4B_CMD    8'hDC
`define SFCD_CHIP_WIPE_CMD             8'h60
`define SFCD_CHIP_WIPE_ALT_CMD         8'hC7
`define SFCD_STATUS1_READ_CMD          8'h05
`define SFCD_STATUS2_READ_CMD          8'h07
`define SFCD_CLEAR_ERROR_STATUS_CMD    8'h30
`define SFCD_WRITE_LOCK_CMD            8'h04
`define SFCD_OP_WREN                   8'h06
`define SFCD_OP_WRR                    8'h01
`define SFCD_OP_RESET                  8'hF0
`define SFCD_MULTI_IO_RESERVED_MODE    8'hA3
`define SFCD_PAGE_MAX                  10'h200
`define SFCD_SR1_BUSY                  0
`define SFCD_SR1_WRITE_LATCH_FLAG      1
`define SFCD_SR1_EFAIL                 5
`define SFCD_SR1_PFAIL                 6
`define SFCD_SR1_NVRW                  7
`define SFCD_ADDR_STATUS               12'h000
`define SFCD_ADDR_MASK                 12'h004
`define SFCD_ADDR_CTRL                 12'h008
`define SFCD_ADDR_SR                   12'h00C
`define SFCD_ADDR_OPCODE               12'h010
`define SFCD_IRQ_CMD                   0
`define SFCD_IRQ_DONE                  1
`define SFCD_IRQ_FAIL                  2
`define SFCD_IRQ_IGNORED               3
`define SFCD_IRQ_W                     4
`endif

/* hdl/sfcd_sync.v */
`timescale 1ns/10ps
`default_nettype none
module sfcd_sync #(
    parameter W = 1
) (
    input  wire         i_clk,
    input  wire         i_rstn,
    input  wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] q_ff;
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_ff <= {W{1'b0}};
            q_ff    <= {W{1'b0}};
        end else begin
            meta_ff <= i_d;
            q_ff    <= meta_ff;
        end
    end
    assign o_q = q_ff;
endmodule
`default_nettype wire

/* hdl/sfcd_spi_rx.v */
`timescale 1ns/10ps
`default_nettype none
// Serial slave, mode 0/3; SCK sampled by system clock, so SCK must stay below clk/4
module sfcd_spi_rx (
    input  wire       i_clk,
    input  wire       i_rstn,
    input  wire       i_sck,
    input  wire       i_csn,
    input  wire       i_si,
    input  wire [7:0] i_tx_byte,
    output reg        o_so,
    output reg        o_byte_vld,
    output reg [7:0]  o_byte,
    output reg        o_first,
    output reg        o_frame_end
);
    wire       sck_s;
    wire       csn_s;
    wire       si_s;
    reg        sck_d_ff;
    reg        csn_d_ff;
    reg [2:0]  bit_ff;
    reg [7:0]  sh_ff;
    reg [7:0]  tx_ff;
    reg        first_ff;
    sfcd_sync #(.W(3)) u_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_d    ({i_sck, i_csn, i_si}),
        .o_q    ({sck_s, csn_s, si_s})
    );
    wire rise = sck_s & ~sck_d_ff & ~csn_s;
    wire fall = ~sck_s & sck_d_ff & ~csn_s;
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sck_d_ff    <= 1'b0;
            csn_d_ff    <= 1'b1;
            bit_ff      <= 3'h0;
            sh_ff       <= 8'h00;
            tx_ff       <= 8'h00;
            first_ff    <= 1'b1;
            o_so        <= 1'b0;
            o_byte_vld  <= 1'b0;
            o_byte      <= 8'h00;
            o_first     <= 1'b0;
            o_frame_end <= 1'b0;
        end else begin
            sck_d_ff    <= sck_s;
            csn_d_ff    <= csn_s;
            o_byte_vld  <= 1'b0;
            // Only frames that carried a byte end; hides the select seen just after reset
            o_frame_end <= csn_s & ~csn_d_ff & ~first_ff;
            if (csn_s) begin
                bit_ff   <= 3'h0;
                first_ff <= 1'b1;
                tx_ff    <= i_tx_byte;
            end else if (rise) begin
                sh_ff  <= {sh_ff[6:0], si_s};
                bit_ff <= bit_ff + 3'h1;
                if (bit_ff == 3'h7) begin
                    o_byte_vld <= 1'b1;
                    o_byte     <= {sh_ff[6:0], si_s};
                    o_first    <= first_ff;
                    first_ff   <= 1'b0;
                end
            end else if (fall) begin
                // Status streams repeatedly, reloaded per byte so polling sees live busy
                // Next MSB leaves on the last fall of a byte, ahead of the host's sampling rise
                if (bit_ff == 3'h0) begin
                    o_so  <= i_tx_byte[7];
                    tx_ff <= {i_tx_byte[6:0], 1'b0};
                end else begin
                    o_so  <= tx_ff[7];
                    tx_ff <= {tx_ff[6:0], 1'b0};
                end
            end
        end
    end
endmodule
`default_nettype wire

/* hdl/sfcd_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "sfcd_regs.vh"
module sfcd_top #(
    parameter OP_CYCLES = 16'h0100
) (
    input  wire        i_clk,
    input  wire        i_rstn,
    input  wire        i_hw_resetn,
    input  wire        i_sck,
    input  wire        i_csn,
    input  wire        i_si,
    output reg         o_so,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    output reg         o_irq,
    output reg         o_prog_start,
    output reg         o_erase_start,
    output reg         o_chip_erase,
    output reg         o_quad,
    output reg         o_addr4
);
    localparam ST_IDLE = 4'h1;
    localparam ST_DATA = 4'h2;
    localparam ST_BUSY = 4'h4;
    localparam ST_FAIL = 4'h8;
    localparam K_NONE  = 3'h0;
    localparam K_PROG  = 3'h1;
    localparam K_ERASE = 3'h2;
    localparam K_NVREG = 3'h3;
    localparam K_CHIP  = 3'h4;

    wire       rx_vld;
    wire [7:0] rx_byte;
    wire       rx_first;
    wire       rx_end;
    wire       rx_so;
    wire       hw_rstn_s;
    reg  [7:0] tx_byte;

    reg [3:0]  st_ff;
    reg [2:0]  kind_ff;
    reg [7:0]  op_ff;
    reg [9:0]  cnt_ff;
    reg [15:0] tmr_ff;
    reg        busy_ff;
    reg        write_latch_flag_ff;
    reg        pfail_ff;
    reg        efail_ff;
    reg        nvrw_ff;
    reg [7:0]  sr2_ff;
    reg [3:0]  irq_st_ff;
    reg [3:0]  irq_mask_ff;
    reg [1:0]  ctrl_ff;
    reg        hw_rst_d_ff;
    reg [3:0]  ev;

    sfcd_sync #(.W(1)) u_rst_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_d    (i_hw_resetn),
        .o_q    (hw_rstn_s)
    );

    sfcd_spi_rx u_rx (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_sck       (i_sck),
        .i_csn       (i_csn),
        .i_si        (i_si),
        .i_tx_byte   (tx_byte),
        .o_so        (rx_so),
        .o_byte_vld  (rx_vld),
        .o_byte      (rx_byte),
        .o_first     (rx_first),
        .o_frame_end (rx_end)
    );

    function is_allowed_in_fail;
        input [7:0] op;
        begin
            is_allowed_in_fail = (op == `SFCD_CLEAR_ERROR_STATUS_CMD) || (op == `SFCD_WRITE_LOCK_CMD) ||
                                 (op == `SFCD_STATUS1_READ_CMD) || (op == `SFCD_STATUS2_READ_CMD) ||
                                 (op == `SFCD_OP_RESET);
        end
    endfunction

    function [2:0] op_kind;
        input [7:0] op;
        begin
            if (op == `SFCD_PAGE_PROGRAM_CMD || op == `SFCD_PAGE_PROGRAM_4B_CMD)
                op_kind = K_PROG;
            else if (op == `SFCD_QUAD_PAGE_PROGRAM_CMD || op == `SFCD_QUAD_PAGE_PROGRAM_ALT_CMD ||
                     op == `SFCD_QUAD_PAGE_PROGRAM_4B_CMD)
                op_kind = K_PROG;
            else if (op == `SFCD_BLOCK_WIPE_512K_CMD || op == `SFCD_BLOCK_WIPE_512K_4B_CMD)
                op_kind = K_ERASE;
            else if (op == `SFCD_CHIP_WIPE_CMD || op == `SFCD_CHIP_WIPE_ALT_CMD)
                op_kind = K_CHIP;
            else if (op == `SFCD_OP_WRR)
                op_kind = K_NVREG;
            else
                op_kind = K_NONE;
        end
    endfunction

    wire [7:0] sr1 = {nvrw_ff, pfail_ff, efail_ff, 3'h0, write_latch_flag_ff,
                      busy_ff | pfail_ff | efail_ff};
    wire       failed = pfail_ff | efail_ff;
    // Address bytes that precede program data in the current frame
    wire [9:0] addr_len = o_addr4 ? 10'h004 : 10'h003;
    wire       sw_rst = rx_vld & rx_first & (rx_byte == `SFCD_OP_RESET);
    wire       hw_rst = ~hw_rstn_s & hw_rst_d_ff;
    wire       apb_acc = i_psel & i_penable;
    wire       apb_wr = apb_acc & i_pwrite;
    wire       apb_rd = apb_acc & ~i_pwrite;

    always @* begin
        // Status byte returned depends on the opcode of the current frame
        if (op_ff == `SFCD_STATUS2_READ_CMD)
            tx_byte = sr2_ff;
        else
            tx_byte = sr1;
    end

    always @* begin
        ev = 4'h0;
        if (rx_vld && rx_first) begin
            ev[`SFCD_IRQ_CMD] = 1'b1;
            if (failed && !is_allowed_in_fail(rx_byte))
                ev[`SFCD_IRQ_IGNORED] = 1'b1;
        end
        if (st_ff == ST_BUSY && tmr_ff == 16'h0000)
            ev[`SFCD_IRQ_DONE] = 1'b1;
        if (rx_end && st_ff == ST_DATA && kind_ff == K_PROG && cnt_ff <= addr_len)
            ev[`SFCD_IRQ_FAIL] = 1'b1;
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            // Same as the synced pin's reset value, so no false edge after reset
            hw_rst_d_ff <= 1'b0;
        end else begin
            hw_rst_d_ff <= hw_rstn_s;
        end
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff         <= ST_IDLE;
            kind_ff       <= K_NONE;
            op_ff         <= 8'h00;
            cnt_ff        <= 10'h000;
            tmr_ff        <= 16'h0000;
            busy_ff       <= 1'b0;
            write_latch_flag_ff <= 1'b0;
            pfail_ff      <= 1'b0;
            efail_ff      <= 1'b0;
            nvrw_ff       <= 1'b0;
            sr2_ff        <= 8'h00;
            o_prog_start  <= 1'b0;
            o_erase_start <= 1'b0;
            o_chip_erase  <= 1'b0;
            o_quad        <= 1'b0;
            o_addr4       <= 1'b0;
        end else begin
            o_prog_start  <= 1'b0;
            o_erase_start <= 1'b0;
            if (hw_rst || sw_rst) begin
                st_ff    <= ST_IDLE;
                busy_ff  <= 1'b0;
                write_latch_flag_ff <= 1'b0;
                pfail_ff <= 1'b0;
                efail_ff <= 1'b0;
                nvrw_ff  <= 1'b0;
                op_ff    <= 8'h00;
            end else begin
                if (ctrl_ff[0] && st_ff == ST_BUSY) begin
                    if (kind_ff == K_PROG)
                        pfail_ff <= 1'b1;
                    else
                        efail_ff <= 1'b1;
                end
                if (rx_vld && rx_first) begin
                    op_ff <= rx_byte;
                    if (failed) begin
                        if (rx_byte == `SFCD_CLEAR_ERROR_STATUS_CMD) begin
                            busy_ff  <= 1'b0;
                            pfail_ff <= 1'b0;
                            efail_ff <= 1'b0;
                            st_ff    <= ST_IDLE;
                        end else if (rx_byte == `SFCD_WRITE_LOCK_CMD) begin
                            write_latch_flag_ff <= 1'b0;
                        end
                    end else if (st_ff == ST_IDLE) begin
                        if (rx_byte == `SFCD_OP_WREN)
                            write_latch_flag_ff <= 1'b1;
                        else if (rx_byte == `SFCD_WRITE_LOCK_CMD)
                            write_latch_flag_ff <= 1'b0;
                        else if (rx_byte == `SFCD_CLEAR_ERROR_STATUS_CMD) begin
                            pfail_ff <= 1'b0;
                            efail_ff <= 1'b0;
                        end else if (write_latch_flag_ff && op_kind(rx_byte) != K_NONE) begin
                            kind_ff <= op_kind(rx_byte);
                            st_ff   <= ST_DATA;
                            cnt_ff  <= 10'h000;
                            o_quad  <= (rx_byte == `SFCD_QUAD_PAGE_PROGRAM_CMD) ||
                                       (rx_byte == `SFCD_QUAD_PAGE_PROGRAM_ALT_CMD) ||
                                       (rx_byte == `SFCD_QUAD_PAGE_PROGRAM_4B_CMD);
                            o_addr4 <= (rx_byte == `SFCD_PAGE_PROGRAM_4B_CMD) ||
                                       (rx_byte == `SFCD_QUAD_PAGE_PROGRAM_4B_CMD) ||
                                       (rx_byte == `SFCD_BLOCK_WIPE_512K_4B_CMD);
                        end
                    end
                end else if (rx_vld && st_ff == ST_DATA) begin
                    // Counts address plus data bytes; capped one past any legal frame so overflow still fails
                    if (cnt_ff != `SFCD_PAGE_MAX + 10'h005)
                        cnt_ff <= cnt_ff + 10'h001;
                    if (kind_ff == K_NVREG && cnt_ff == 10'h000)
                        sr2_ff <= rx_byte;
                end
                if (rx_end && st_ff == ST_DATA) begin
                    // A program with no data byte after its address fails
                    if (kind_ff == K_PROG && cnt_ff <= addr_len) begin
                        st_ff    <= ST_FAIL;
                        pfail_ff <= 1'b1;
                        write_latch_flag_ff <= 1'b0;
                    end else if (kind_ff == K_PROG && cnt_ff > `SFCD_PAGE_MAX + addr_len) begin
                        st_ff    <= ST_FAIL;
                        pfail_ff <= 1'b1;
                        write_latch_flag_ff <= 1'b0;
                    end else begin
                        st_ff         <= ST_BUSY;
                        busy_ff       <= 1'b1;
                        tmr_ff        <= OP_CYCLES;
                        nvrw_ff       <= (kind_ff == K_NVREG);
                        o_prog_start  <= (kind_ff == K_PROG);
                        o_erase_start <= (kind_ff == K_ERASE) || (kind_ff == K_CHIP);
                        o_chip_erase  <= (kind_ff == K_CHIP);
                    end
                end
                if (st_ff == ST_BUSY) begin
                    if (tmr_ff != 16'h0000)
                        tmr_ff <= tmr_ff - 16'h0001;
                    else if (!failed && !ctrl_ff[0]) begin
                        st_ff   <= ST_IDLE;
                        busy_ff <= 1'b0;
                        write_latch_flag_ff <= 1'b0;
                        nvrw_ff <= 1'b0;
                    end else
                        st_ff <= ST_FAIL;
                end
            end
        end
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_prdata    <= 32'h00000000;
            o_pready    <= 1'b0;
            o_pslverr   <= 1'b0;
            o_irq       <= 1'b0;
            o_so        <= 1'b0;
            irq_st_ff   <= 4'h0;
            irq_mask_ff <= 4'h0;
            ctrl_ff     <= 2'h0;
        end else begin
            o_so      <= rx_so;
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= 1'b0;
            // Set wins over read-clear
            if (apb_rd && o_pready && i_paddr == `SFCD_ADDR_STATUS)
                irq_st_ff <= ev;
            else
                irq_st_ff <= irq_st_ff | ev;
            o_irq <= |((irq_st_ff | ev) & irq_mask_ff);
            if (i_psel && !i_penable) begin
                if (i_paddr == `SFCD_ADDR_STATUS)
                    o_prdata <= {28'h0000000, irq_st_ff};
                else if (i_paddr == `SFCD_ADDR_MASK)
                    o_prdata <= {28'h0000000, irq_mask_ff};
                else if (i_paddr == `SFCD_ADDR_CTRL)
                    o_prdata <= {30'h00000000, ctrl_ff};
                else if (i_paddr == `SFCD_ADDR_SR)
                    o_prdata <= {16'h0000, sr2_ff, sr1};
                else if (i_paddr == `SFCD_ADDR_OPCODE)
                    o_prdata <= {20'h00000, st_ff, op_ff};
                else begin
                    o_prdata  <= 32'h00000000;
                    o_pslverr <= 1'b1;
                end
            end
            if (apb_wr && o_pready) begin
                if (i_paddr == `SFCD_ADDR_MASK)
                    irq_mask_ff <= i_pwdata[3:0];
                else if (i_paddr == `SFCD_ADDR_CTRL)
                    ctrl_ff <= i_pwdata[1:0];
            end
        end
    end
endmodule
`default_nettype wire

/* verif/sfcd_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module sfcd_props #(
    parameter OP_CYCLES = 16'h0100
) (
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_hw_resetn,
    input wire logic        i_sck,
    input wire logic        i_csn,
    input wire logic        i_si,
    input wire logic        o_so,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_irq,
    input wire logic        o_prog_start,
    input wire logic        o_erase_start,
    input wire logic        o_chip_erase,
    input wire logic        o_quad,
    input wire logic        o_addr4
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    property p_prog_pulse;
        o_prog_start |=> !o_prog_start;
    endproperty
    a_prog_pulse: assert property (p_prog_pulse) else $error("program start too long");
    property p_erase_pulse;
        o_erase_start |=> !o_erase_start;
    endproperty
    a_erase_pulse: assert property (p_erase_pulse) else $error("erase start too long");
    property p_one_kind;
        !(o_prog_start && o_erase_start);
    endproperty
    a_one_kind: assert property (p_one_kind) else $error("program and erase together");
    // Busy window forbids a second start soon after
    property p_start_gap;
        (o_prog_start || o_erase_start) |=> !(o_prog_start || o_erase_start) [*8];
    endproperty
    a_start_gap: assert property (p_start_gap) else $error("start while busy");
    property p_start_frame;
        (o_prog_start || o_erase_start) |-> $past(i_csn, 2);
    endproperty
    a_start_frame: assert property (p_start_frame) else $error("start inside a frame");
    property p_prog_kind;
        o_prog_start |=> !o_chip_erase;
    endproperty
    a_prog_kind: assert property (p_prog_kind) else $error("program marked as chip wipe");
    property p_erase_kind;
        o_erase_start |=> !o_quad;
    endproperty
    a_erase_kind: assert property (p_erase_kind) else $error("erase marked as quad");
    property p_apb_answer;
        i_psel && !i_penable |=> o_pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("no ready after setup");
    property p_apb_idle;
        !i_psel |=> !o_pready;
    endproperty
    a_apb_idle: assert property (p_apb_idle) else $error("ready without select");
    property p_unmapped;
        i_psel && !i_penable && i_paddr > 12'h010 |=> o_pslverr && o_prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_err_ready;
        o_pslverr |-> o_pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
endmodule
bind sfcd_top sfcd_props #(.OP_CYCLES(OP_CYCLES)) i_props (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_hw_resetn(i_hw_resetn), .i_sck(i_sck), .i_csn(i_csn),
    .i_si(i_si), .o_so(o_so), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_irq(o_irq), .o_prog_start(o_prog_start), .o_erase_start(o_erase_start),
    .o_chip_erase(o_chip_erase), .o_quad(o_quad), .o_addr4(o_addr4));
`default_nettype wire

/* verif/sfcd_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sfcd_host_model (
    output logic      o_sck,
    output logic      o_csn,
    output logic      o_si,
    input wire logic  i_so
);
    logic [7:0] rx;
    initial begin
        o_sck = 1'b0;
        o_csn = 1'b1;
        o_si  = 1'b0;
    end
    // 80 ns link clock, idle low between frames
    task automatic frame(input logic [7:0] q[$]);
        o_csn = 1'b0;
        foreach (q[i]) begin
            for (int b = 7; b >= 0; b--) begin
                o_si = q[i][b];
                #40 o_sck = 1'b1;
                #39 rx = {rx[6:0], i_so};
                #1 o_sck = 1'b0;
            end
        end
        #40 o_csn = 1'b1;
        o_si = ~o_si; // Released line must not look held
        #200;
    endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sfcd_regs.vh"
`define CHK(n, e, s) chk(n, 32'(e), 32'(s))
module testbench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hwrn = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, irq, ps, es, ce, qd, a4, err;
    wire         sck, csn, si, so;
    int          num_errors = 0, cmp_count = 0, nps = 0, nes = 0, seed;
    logic [7:0]  q[$], ops[$], e1, b;
    logic [3:0]  k;
    int          plen[$];
    sfcd_top #(.OP_CYCLES(16'h0040)) i_dut (.i_clk(clk), .i_rstn(rstn), .i_hw_resetn(hwrn),
        .i_sck(sck), .i_csn(csn), .i_si(si), .o_so(so), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_irq(irq), .o_prog_start(ps), .o_erase_start(es),
        .o_chip_erase(ce), .o_quad(qd), .o_addr4(a4));
    sfcd_host_model i_host (.o_sck(sck), .o_csn(csn), .o_si(si), .i_so(so));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (ps === 1'b1) nps++;
        if (es === 1'b1) nes++;
    end
    task end_of_test;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, s);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        {psel, pen} <= 2'b00;
        if (n >= 20) begin
            num_errors++;
            end_of_test;
        end
    endtask
    task automatic rd_sr;
        apb(1'b0, `SFCD_ADDR_SR, 32'h0);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            rd_sr;
            n++;
        end while (rd[0] !== 1'b0 && n < 100);
        if (n >= 100) begin
            num_errors++;
            end_of_test;
        end
    endtask
    // Bits: program, quad, four-byte address, chip wipe
    function automatic logic [3:0] kind(input logic [7:0] op);
        kind[3] = op == 8'h02 || op == 8'h12 || op == 8'h32 || op == 8'h38 || op == 8'h34;
        kind[2] = op == 8'h32 || op == 8'h38 || op == 8'h34;
        kind[1] = op == 8'h12 || op == 8'h34 || op == 8'hDC;
        kind[0] = op == 8'h60 || op == 8'hC7;
    endfunction
    function automatic logic [7:0] sr1(input logic bsy, wl, ef, pf);
        sr1 = {1'b0, pf, ef, 3'b000, wl, bsy | ef | pf};
    endfunction
    initial begin
        seed = 16;
        ops = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'hD8, 8'hDC, 8'h60, 8'hC7};
        plen = '{0, 512, 513};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_sr;
        `CHK("sr_rst", 0, rd[15:0]);
        apb(1'b0, 12'h020, 32'h0);
        `CHK("unmapped", 1, err);
        apb(1'b1, `SFCD_ADDR_MASK, 32'h0000000F);
        foreach (ops[i]) begin
            k = kind(ops[i]);
            nps = 0;
            nes = 0;
            i_host.frame('{8'h06});
            q = '{ops[i]};
            if (!k[0]) repeat (3 + k[1]) q.push_back(8'($random(seed)));
            if (k[3]) repeat (1 + ($random(seed) & 3)) q.push_back(8'($random(seed)));
            i_host.frame(q);
            rd_sr;
            `CHK("sr_busy", 8'h03, rd[7:0]);
            `CHK("prog_start", k[3], nps);
            `CHK("erase_start", !k[3], nes);
            `CHK("kind", k[2:0], {qd, a4, ce});
            wait_idle;
            `CHK("sr_done", 0, rd[7:0]);
        end
        `CHK("irq_on", 1, irq);
        apb(1'b0, `SFCD_ADDR_STATUS, 32'h0);
        `CHK("irq_st", 3, rd[1:0]);
        repeat (2) @(posedge clk);
        `CHK("irq_off", 0, irq);
        for (int f = 0; f < 3; f++) begin
            i_host.frame('{8'h06});
            q = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h5A};
            if (f > 0) q = '{8'hD8, 8'h00, 8'h00, 8'h00};
            i_host.frame(q);
            apb(1'b1, `SFCD_ADDR_CTRL, 32'h1);
            apb(1'b1, `SFCD_ADDR_CTRL, 32'h0);
            repeat (80) @(posedge clk);
            e1 = sr1(1'b1, 1'b1, f > 0, f == 0);
            rd_sr;
            `CHK("sr_fail", e1, rd[7:0]);
            i_host.frame('{8'h05, 8'h00, 8'h00});
            `CHK("spi_sr1", e1, i_host.rx);
            nes = 0;
            i_host.frame('{8'h06});
            i_host.frame('{8'hDC, 8'h00, 8'h00, 8'h00, 8'h00});
            rd_sr;
            `CHK("sr_ignored", e1, rd[7:0]);
            `CHK("no_start", 0, nes);
            apb(1'b0, `SFCD_ADDR_STATUS, 32'h0);
            `CHK("irq_ignored", 1, rd[3]);
            if (f == 0) begin
                i_host.frame('{8'h30});
                rd_sr;
                `CHK("sr_cleared", 8'h02, rd[7:0]);
                i_host.frame('{8'h04});
            end else if (f == 1) begin
                i_host.frame('{8'hF0});
            end else begin
                hwrn <= 1'b0;
                repeat (4) @(posedge clk);
                hwrn <= 1'b1;
                repeat (4) @(posedge clk);
            end
            rd_sr;
            `CHK("sr_standby", 0, rd[7:0]);
        end
        foreach (plen[j]) begin
            i_host.frame('{8'h06});
            q = '{8'h02, 8'h00, 8'h02, 8'h00};
            repeat (plen[j]) q.push_back(8'($random(seed)));
            i_host.frame(q);
            repeat (80) @(posedge clk);
            rd_sr;
            `CHK("len_fail", plen[j] != 512, rd[6]);
            i_host.frame('{8'hF0});
        end
        b = 8'($random(seed));
        i_host.frame('{8'h06});
        i_host.frame('{8'h01, b});
        rd_sr;
        `CHK("nv_busy", 8'h83, rd[7:0]);
        wait_idle;
        `CHK("sr2", b, rd[15:8]);
        i_host.frame('{8'h07, 8'h00, 8'h00});
        `CHK("spi_sr2", b, i_host.rx);
        nps = 0;
        nes = 0;
        i_host.frame('{8'h06});
        i_host.frame('{8'hA3, 8'h00, 8'h00, 8'h00});
        rd_sr;
        `CHK("mpm_sr", 8'h02, rd[7:0]);
        `CHK("mpm_start", 0, nps + nes);
        apb(1'b0, `SFCD_ADDR_OPCODE, 32'h0);
        `CHK("last_op", 8'hA3, rd[7:0]);
        apb(1'b1, `SFCD_ADDR_MASK, 32'h0);
        apb(1'b0, `SFCD_ADDR_STATUS, 32'h0);
        i_host.frame('{8'h04});
        `CHK("irq_masked", 0, irq);
        apb(1'b0, `SFCD_ADDR_STATUS, 32'h0);
        `CHK("irq_raw", 1, rd[0]);
        end_of_test;
    end
endmodule
`default_nettype wire
